// >>> hdl/adc_trigger_window_detect.v
// Converter trigger selection, window detector and Avalon-MM registers
`timescale 1ns/1ps
`include "adc_ctl_defs.vh"

// Overview of operation
// - Mode 000: software writing one to busy bit starts a conversion.
// - Mode 001: each timer 0 overflow while not busy starts a conversion.
// - Modes 010, 011, 100: timer 2, timer 1 overflow, external pin rising edge; codes 101 to 111 never start.
// - Window detector compares results with limits without software help.
// - A window condition sets the match flag and raises the interrupt.
// - Software can read the match flag for polling.
// - Limits come from greater-than and less-than byte pairs.
// - Relative limit values choose inside or outside detection.
// - Flag one means a match occurred since the last clear.
// - Greater-than high byte: read/write, index C4, resets to FF.
// - Less-than above greater-than: flag gt < result < lt.
// - Outside setting: flag result below gt or above lt.
// - Differential mode compares signed values, single-ended unsigned.
// - Flag stays set until cleared; cleared reads zero until next match.
module adc_trigger_window_detect
(
  input  wire        ref_clk,
  input  wire        rst_n,
  // Avalon-MM slave
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output reg  [1:0]  avs_response,
  // Trigger sources
  input  wire        timer0_overflow,
  input  wire        timer1_overflow,
  input  wire        timer2_overflow,
  input  wire        external_convert_start_pin,
  // Converter core
  output reg         conv_start,
  input  wire        conv_done,
  input  wire [15:0] conv_result,
  // Interrupt
  output wire        irq
);

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  reg  [2:0]  conv_trigger_mode_reg;
  reg         window_match_flag_reg;
  reg         conv_busy_bit_reg;
  reg         diff_mode_reg;
  reg  [7:0]  window_gt_limit_high_reg;
  reg  [7:0]  window_gt_limit_low_reg;
  reg  [7:0]  window_lt_limit_high_reg;
  reg  [7:0]  window_lt_limit_low_reg;
  reg  [7:0]  result_high_byte_reg;
  reg  [7:0]  result_low_byte_reg;
  reg  [1:0]  irq_status_reg;
  reg  [1:0]  irq_enable_reg;
  reg         pin_prev_reg;
  reg         check_pending_reg;
  reg         ack_reg;

  wire        pin_sync;
  wire        window_hit;
  wire [7:0]  word_index;
  wire        access;
  wire        do_write;
  wire        do_read;
  wire        mapped;
  wire [7:0]  wbyte;
  wire        wlane;

  //--------------------------------------------------------------------
  // Pin synchroniser
  //--------------------------------------------------------------------
  sync_two_ff u_pin_sync
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (external_convert_start_pin),
    .sync_out (pin_sync)
  );

  //--------------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------------
  // One wait cycle gives registered read data a cycle to settle
  assign word_index      = avs_address[9:2];
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_reg;
  assign do_write        = avs_write & ack_reg;
  assign do_read         = avs_read & ~ack_reg;
  assign wbyte           = avs_writedata[7:0];
  assign wlane           = avs_byteenable[0];
  assign mapped = (word_index == `IDX_CONV_CTRL)   |
                  (word_index == `IDX_RESULT_LOW)  |
                  (word_index == `IDX_RESULT_HIGH) |
                  (word_index == `IDX_GT_LOW)      |
                  (word_index == `IDX_GT_HIGH)     |
                  (word_index == `IDX_LT_LOW)      |
                  (word_index == `IDX_LT_HIGH)     |
                  (word_index == `IDX_CONFIG)      |
                  (word_index == `IDX_IRQ_STATUS)  |
                  (word_index == `IDX_IRQ_ENABLE)  |
                  (word_index == `IDX_IRQ_CLEAR);

  // Acknowledge toggles so each request gets exactly one wait cycle
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= access & ~ack_reg;
  end

  //--------------------------------------------------------------------
  // Read data
  //--------------------------------------------------------------------
  // Captured in the wait cycle, presented when waitrequest drops
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end
    else if (do_read)
    begin
      avs_response <= mapped ? 2'h0 : 2'h3;
      case (word_index)
        `IDX_CONV_CTRL:
          avs_readdata <= {24'h000000, 3'h0, conv_busy_bit_reg,
                           window_match_flag_reg,
                           conv_trigger_mode_reg};
        `IDX_RESULT_LOW:  avs_readdata <= {24'h000000, result_low_byte_reg};
        `IDX_RESULT_HIGH: avs_readdata <= {24'h000000, result_high_byte_reg};
        `IDX_GT_LOW:
          avs_readdata <= {24'h000000, window_gt_limit_low_reg};
        `IDX_GT_HIGH:
          avs_readdata <= {24'h000000, window_gt_limit_high_reg};
        `IDX_LT_LOW:
          avs_readdata <= {24'h000000, window_lt_limit_low_reg};
        `IDX_LT_HIGH:
          avs_readdata <= {24'h000000, window_lt_limit_high_reg};
        `IDX_CONFIG:     avs_readdata <= {31'h00000000, diff_mode_reg};
        `IDX_IRQ_STATUS: avs_readdata <= {30'h00000000, irq_status_reg};
        `IDX_IRQ_ENABLE: avs_readdata <= {30'h00000000, irq_enable_reg};
        default:         avs_readdata <= 32'h00000000;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Configuration and limit registers
  //--------------------------------------------------------------------
  // Byte lane 0 carries every register; other lanes are ignored
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_trigger_mode_reg    <= 3'h0;
      diff_mode_reg            <= 1'b0;
      window_gt_limit_high_reg <= `RST_GT_HIGH;
      window_gt_limit_low_reg  <= `RST_GT_LOW;
      window_lt_limit_high_reg <= `RST_LT_HIGH;
      window_lt_limit_low_reg  <= `RST_LT_LOW;
      irq_enable_reg           <= 2'h0;
    end
    else if (do_write && wlane)
    begin
      case (word_index)
        `IDX_CONV_CTRL:
          conv_trigger_mode_reg <= wbyte[`CTRL_MODE_LSB+2:`CTRL_MODE_LSB];
        `IDX_GT_HIGH:    window_gt_limit_high_reg <= wbyte;
        `IDX_GT_LOW:     window_gt_limit_low_reg  <= wbyte;
        `IDX_LT_HIGH:    window_lt_limit_high_reg <= wbyte;
        `IDX_LT_LOW:     window_lt_limit_low_reg  <= wbyte;
        `IDX_CONFIG:     diff_mode_reg  <= wbyte[`CFG_DIFF_BIT];
        `IDX_IRQ_ENABLE: irq_enable_reg <= wbyte[1:0];
        default:         diff_mode_reg  <= diff_mode_reg;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Trigger selection
  //--------------------------------------------------------------------
  wire sw_start;
  wire pin_rise;
  reg  trigger;
  assign sw_start = do_write && wlane && (word_index == `IDX_CONV_CTRL) &&
                    wbyte[`CTRL_BUSY_BIT];
  assign pin_rise = pin_sync & ~pin_prev_reg;

  // Only the selected source can start; unused codes never start
  always @*
  begin
    case (conv_trigger_mode_reg)
      `MODE_SOFTWARE: trigger = sw_start;
      `MODE_TIMER0:   trigger = timer0_overflow;
      `MODE_TIMER2:   trigger = timer2_overflow;
      `MODE_TIMER1:   trigger = timer1_overflow;
      `MODE_EXT_PIN:  trigger = pin_rise;
      default:        trigger = 1'b0;
    endcase
  end

  // A start while busy is dropped; the core is still converting
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_prev_reg      <= 1'b0;
      conv_start        <= 1'b0;
      conv_busy_bit_reg <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= pin_sync;
      conv_start   <= trigger & ~conv_busy_bit_reg;
      if (trigger && !conv_busy_bit_reg)
        conv_busy_bit_reg <= 1'b1;
      else if (conv_done)
        conv_busy_bit_reg <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Result capture and window check
  //--------------------------------------------------------------------
  window_compare u_window
  (
    .result_word (conv_result),
    .gt_limit    ({window_gt_limit_high_reg, window_gt_limit_low_reg}),
    .lt_limit    ({window_lt_limit_high_reg, window_lt_limit_low_reg}),
    .diff_mode   (diff_mode_reg),
    .match       (window_hit)
  );

  // Result pair loads on each completed conversion
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_high_byte_reg <= 8'h00;
      result_low_byte_reg  <= 8'h00;
      check_pending_reg    <= 1'b0;
    end
    else
    begin
      check_pending_reg <= conv_done & window_hit;
      if (conv_done)
      begin
        result_high_byte_reg <= conv_result[15:8];
        result_low_byte_reg  <= conv_result[7:0];
      end
    end
  end

  //--------------------------------------------------------------------
  // Match flag and interrupt status
  //--------------------------------------------------------------------
  wire ctrl_wr;
  wire clr_wr;
  assign ctrl_wr = do_write && wlane && (word_index == `IDX_CONV_CTRL);
  assign clr_wr  = do_write && wlane && (word_index == `IDX_IRQ_CLEAR);

  // Set wins over a clear in the same cycle so no match is lost
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      window_match_flag_reg <= 1'b0;
      irq_status_reg        <= 2'h0;
    end
    else
    begin
      if (check_pending_reg)
        window_match_flag_reg <= 1'b1;
      else if (ctrl_wr && !wbyte[`CTRL_WINT_BIT])
        window_match_flag_reg <= 1'b0;
      else if (clr_wr && wbyte[`IRQ_WINDOW_BIT])
        window_match_flag_reg <= 1'b0;
      irq_status_reg[`IRQ_WINDOW_BIT] <= check_pending_reg |
        (irq_status_reg[`IRQ_WINDOW_BIT] &
         ~(clr_wr & wbyte[`IRQ_WINDOW_BIT]) &
         ~(ctrl_wr & ~wbyte[`CTRL_WINT_BIT]));
      irq_status_reg[`IRQ_DONE_BIT] <= conv_done |
        (irq_status_reg[`IRQ_DONE_BIT] & ~(clr_wr & wbyte[`IRQ_DONE_BIT]));
    end
  end

  // Level interrupt while any enabled status bit is set
  assign irq = |(irq_status_reg & irq_enable_reg);

endmodule // adc_trigger_window_detect

// >>> hdl/sync_two_ff.v
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync_two_ff
(
  input  wire ref_clk,
  input  wire rst_n,
  input  wire async_in,
  output reg  sync_out
);

  reg meta_reg;

  // First stage is read only by the second stage
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sync_two_ff

// >>> hdl/window_compare.v
// Window comparator for one 16-bit result against two limits
`timescale 1ns/1ps
module window_compare
(
  input  wire [15:0] result_word,
  input  wire [15:0] gt_limit,
  input  wire [15:0] lt_limit,
  input  wire        diff_mode,
  output wire        match
);

  // Flip the sign bit so that signed order becomes unsigned order
  wire [15:0] flip;
  wire [15:0] r_k;
  wire [15:0] gt_k;
  wire [15:0] lt_k;
  assign flip = diff_mode ? 16'h8000 : 16'h0000;
  assign r_k  = result_word ^ flip;
  assign gt_k = gt_limit ^ flip;
  assign lt_k = lt_limit ^ flip;

  // Inside window when lt is above gt, outside otherwise
  wire above_gt;
  wire below_lt;
  assign above_gt = r_k > gt_k;
  assign below_lt = r_k < lt_k;
  assign match = (lt_k > gt_k) ? (above_gt & below_lt)
                               : ((r_k < gt_k) | (r_k > lt_k));

endmodule // window_compare

// >>> pkg/adc_ctl_defs.vh
// Register offsets, field positions, reset values and timing constants
`ifndef ADC_CTL_DEFS_VH
`define ADC_CTL_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_CONV_CTRL        8'hE8
`define IDX_RESULT_LOW       8'hBD
`define IDX_RESULT_HIGH      8'hBE
`define IDX_GT_LOW           8'hC3
`define IDX_GT_HIGH          8'hC4
`define IDX_LT_LOW           8'hC5
`define IDX_LT_HIGH          8'hC6
`define IDX_CONFIG           8'hF0
`define IDX_IRQ_STATUS       8'hF1
`define IDX_IRQ_ENABLE       8'hF2
`define IDX_IRQ_CLEAR        8'hF3

// Fields of the converter control register
`define CTRL_MODE_LSB        0
`define CTRL_WINT_BIT        3
`define CTRL_BUSY_BIT        4

// Fields of the configuration register
`define CFG_DIFF_BIT         0

// Interrupt status bits
`define IRQ_WINDOW_BIT       0
`define IRQ_DONE_BIT         1

// Trigger mode encodings
`define MODE_SOFTWARE        3'h0
`define MODE_TIMER0          3'h1
`define MODE_TIMER2          3'h2
`define MODE_TIMER1          3'h3
`define MODE_EXT_PIN         3'h4

// Reset values
`define RST_GT_HIGH          8'hFF
`define RST_GT_LOW           8'hFF
`define RST_LT_HIGH          8'h00
`define RST_LT_LOW           8'h00
`define RST_CTRL             8'h00

// Register bus latency in cycles before waitrequest drops
`define BUS_WAIT_CYCLES      1

`endif

// >>> test/adc_core_model.sv
// Behavioural converter core that answers each start pulse with a result
`timescale 1ns/1ps
module adc_core_model
(
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        conv_start,
  input  wire [15:0] next_result,
  input  wire [3:0]  latency,
  output reg         conv_done,
  output reg  [15:0] conv_result
);
  reg [3:0] count_reg;
  // Count out the conversion, then present the result for one cycle;
  // the result bus toggles otherwise so stale data never looks valid
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg   <= 4'h0;
      conv_done   <= 1'b0;
      conv_result <= 16'h0000;
    end
    else
    begin
      conv_done   <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start)
        count_reg <= latency;
      else if (count_reg == 4'h1)
      begin
        count_reg   <= 4'h0;
        conv_done   <= 1'b1;
        conv_result <= next_result;
      end
      else if (count_reg != 4'h0)
        count_reg <= count_reg - 4'h1;
    end
  end
endmodule // adc_core_model

// >>> test/adc_trigger_window_detect_sva.sv
// Port-level assertions for trigger selection and window interrupt
`timescale 1ns/1ps
module adc_window_checker
(
  input wire        ref_clk,
  input wire        rst_n,
  input wire [9:0]  avs_address,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire        timer0_overflow,
  input wire        timer1_overflow,
  input wire        timer2_overflow,
  input wire        conv_start,
  input wire        conv_done,
  input wire        irq
);
  reg  [2:0] mode_reg;
  reg        busy_reg;
  // Accepted writes, decoded by word index
  wire       wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire [7:0] idx = avs_address[9:2];
  wire       en_wr = wr_ok && idx == 8'hF2;
  wire       clr_wr = wr_ok && (idx == 8'hF3 || idx == 8'hF2 || idx == 8'hE8);
  wire       clr_all = wr_ok && idx == 8'hF3 && avs_writedata[1:0] == 2'h3;
  wire       idle = !busy_reg && !conv_start;
  // Shadow of the mode field and of a conversion in flight
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= 3'h0;
      busy_reg <= 1'b0;
    end
    else
    begin
      if (wr_ok && idx == 8'hE8)
        mode_reg <= avs_writedata[2:0];
      busy_reg <= conv_start | (busy_reg & !conv_done);
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_sw_start;
    wr_ok && idx == 8'hE8 && avs_writedata[4] && avs_writedata[2:0] == 3'h0
      && mode_reg == 3'h0 && idle;
  endsequence
  sequence s_timer_start;
    idle && ((mode_reg == 3'h2 && timer2_overflow)
      || (mode_reg == 3'h3 && timer1_overflow));
  endsequence
  a_start_single: assert property (conv_start |=> !conv_start)
    else $error("Start pulse longer than one cycle");
  a_sw_start: assert property (s_sw_start |=> conv_start)
    else $error("Software start did not launch");
  a_timer0_start: assert property
    (mode_reg == 3'h1 && timer0_overflow && idle |=> conv_start)
    else $error("Timer 0 overflow did not launch");
  a_other_start: assert property (s_timer_start |=> conv_start)
    else $error("Timer 1 or 2 overflow did not launch");
  a_start_idle: assert property (conv_start |-> !busy_reg)
    else $error("Start issued while converting");
  a_irq_cause: assert property
    ($rose(irq) |-> $past(conv_done) || $past(conv_done, 2) || $past(en_wr))
    else $error("Interrupt rose without a result or enable");
  a_irq_sticky: assert property ($fell(irq) |-> $past(clr_wr))
    else $error("Interrupt dropped without software action");
  a_irq_cleared: assert property
    (clr_all && !conv_done && !$past(conv_done) |=> !irq)
    else $error("Interrupt stayed after full clear");
endmodule // adc_window_checker

// >>> test/testbench.sv
// Self-checking bench for converter trigger and window detector
`timescale 1ns/1ps
module testbench;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [9:0]  avs_address = 10'h000;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'hF;
  reg  [2:0]  tmr = 3'h0;
  reg         ext_pin = 1'b0;
  reg  [15:0] next_result = 16'h0000;
  reg  [3:0]  latency = 4'h2;
  reg  [31:0] seed = 32'h34DFAFFB;
  reg  [15:0] gt, lt, res;
  reg  [7:0]  rdq, sel, clr;
  reg  [1:0]  rsp;
  reg         dif;
  wire [31:0] avs_readdata;
  wire [15:0] conv_result;
  wire [1:0]  avs_response;
  wire        avs_waitrequest, conv_start, conv_done, irq;
  integer     n_errors = 0, check_count = 0, starts = 0, dones = 0;
  integer     k, md, n, s0, hit;
  adc_trigger_window_detect i_dut (.ref_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .timer0_overflow(tmr[0]),
    .timer1_overflow(tmr[1]), .timer2_overflow(tmr[2]),
    .external_convert_start_pin(ext_pin), .conv_start, .conv_done,
    .conv_result, .irq);
  adc_core_model i_core (.ref_clk, .rst_n, .conv_start, .next_result,
    .latency, .conv_done, .conv_result);
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  // Count launches and results seen at the ports
  always @(posedge ref_clk)
  begin
    starts <= starts + (conv_start === 1'b1);
    dones <= dones + (conv_done === 1'b1);
  end
  // ----------------------------------------------------------------
  // Helpers and reference model
  // ----------------------------------------------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function integer sx(input [15:0] v, input d);
  begin
    sx = v;
    if (d && v[15])
      sx = sx - 65536;
  end
  endfunction
  // Inside when the less-than limit is above, else outside
  function integer win(input [15:0] r, g, l, input d);
    if (sx(l, d) > sx(g, d))
      win = sx(r, d) > sx(g, d) && sx(r, d) < sx(l, d);
    else
      win = sx(r, d) < sx(g, d) || sx(r, d) > sx(l, d);
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // Bus transfer held until waitrequest is low at a rising edge
  task xfer(input rd, input [7:0] ix, input [7:0] d);
  begin
    @(posedge ref_clk);
    avs_address <= {ix, 2'b00};
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    n = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      n = n + 1;
      @(posedge ref_clk);
    end
    // Answer is taken at the accepting rising edge, then released
    n_errors = n_errors + (avs_waitrequest !== 1'b0);
    if (avs_waitrequest !== 1'b0)
      give_verdict;
    rdq = avs_readdata[7:0];
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  end
  endtask
  task rchk(input [7:0] ix, input [7:0] exp);
  begin
    xfer(1'b1, ix, 8'h00);
    chk(rdq, exp);
  end
  endtask
  // Reset values, unmapped access, then conversions over the five starting modes
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(8'hC4, 8'hFF);
    rchk(8'hC3, 8'hFF);
    rchk(8'hC6, 8'h00);
    rchk(8'h00, 8'h00);
    chk(rsp, 2'h3);
    xfer(1'b0, 8'hC4, seed[7:0]);
    rchk(8'hC4, seed[7:0]);
    // Unused trigger code 5 never starts, whatever pulses arrive
    xfer(1'b0, 8'hE8, 8'h05);
    xfer(1'b0, 8'hE8, 8'h15);
    tmr <= 3'h7;
    ext_pin <= 1'b1;
    @(posedge ref_clk);
    tmr <= 3'h0;
    repeat (4) @(posedge ref_clk);
    ext_pin <= 1'b0;
    chk(starts, 0);
    for (k = 0; k < 40; k = k + 1)
    begin
      seed = lfsr(seed);
      md = k % 5;
      dif = k % 4 > 1;
      gt = k % 4 == 1 ? 16'h0080 : k % 4 == 2 ? 16'hFFFF : 16'h0040;
      lt = k % 4 == 0 ? 16'h0080 : k % 4 == 3 ? 16'hFFFF : 16'h0040;
      res = (k / 4) % 4 == 1 ? gt : (k / 4) % 4 == 2 ? gt + 16'h1 :
            (k / 4) % 4 == 3 ? lt : {{8{dif & seed[7]}}, seed[7:0]};
      hit = win(res, gt, lt, dif);
      sel = md == 1 ? 8'h1 : md == 2 ? 8'h4 : md == 3 ? 8'h2 : 8'h0;
      xfer(1'b0, 8'hC3, gt[7:0]);
      xfer(1'b0, 8'hC4, gt[15:8]);
      xfer(1'b0, 8'hC5, lt[7:0]);
      xfer(1'b0, 8'hC6, lt[15:8]);
      xfer(1'b0, 8'hF0, {7'h0, dif});
      xfer(1'b0, 8'hF2, {7'h0, k[0]});
      xfer(1'b0, 8'hE8, md[7:0]);
      next_result <= res;
      latency <= 4'h2 + k % 3;
      s0 = starts;
      tmr <= ~sel[2:0];
      @(posedge ref_clk);
      tmr <= 3'h0;
      repeat (4) @(posedge ref_clk);
      chk(starts, s0);
      if (md == 0)
        xfer(1'b0, 8'hE8, 8'h10);
      ext_pin <= md == 4;
      tmr <= sel[2:0];
      @(posedge ref_clk);
      tmr <= 3'h0;
      repeat (4) @(posedge ref_clk);
      ext_pin <= 1'b0;
      for (n = 0; dones <= k && n < 100; n = n + 1)
        @(posedge ref_clk);
      // A conversion that never completes ends the run as a failure
      if (dones <= k)
      begin
        n_errors = n_errors + 1;
        give_verdict;
      end
      chk(starts, s0 + 1);
      rchk(8'hBD, res[7:0]);
      rchk(8'hBE, res[15:8]);
      rchk(8'hF1, {6'h0, 1'b1, hit[0]});
      rchk(8'hE8, {4'h0, hit[0], md[2:0]});
      chk(irq, k[0] & hit[0]);
      clr = k % 4 == 1 ? 8'h2 : 8'h3;
      if (k % 2)
        xfer(1'b0, 8'hF3, clr);
      if (k % 2)
        rchk(8'hF1, {6'h0, 1'b1, hit[0]} & ~clr);
    end
    give_verdict;
  end
endmodule // testbench
bind adc_trigger_window_detect adc_window_checker i_chk (.ref_clk, .rst_n,
  .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .timer0_overflow, .timer1_overflow, .timer2_overflow,
  .conv_start, .conv_done, .irq);
